// File: core/hsp_pkg.sv
// package for the high-speed port routing and status register bank
// assumes a 32-bit register port with byte offsets from the controller base
package hsp_pkg;
   localparam int          NUM_PORTS       = 4;
   localparam logic [7:0]  OFS_PORT_SC     = 8'h50;
   localparam logic [7:0]  OFS_ROUTING     = 8'h4C;
   // field positions inside port_status_control
   localparam int          B_CONN_STAT     = 0;
   localparam int          B_CONN_CHG      = 1;
   localparam int          B_PORT_EN       = 2;
   localparam int          B_EN_CHG        = 3;
   localparam int          B_OC_ACT        = 4;
   localparam int          B_OC_CHG        = 5;
   localparam int          B_FORCE_RES     = 6;
   localparam int          B_SUSPEND       = 7;
   localparam int          B_PORT_RESET    = 8;
   localparam int          B_LINE_LO       = 10;
   localparam int          B_POWER         = 12;
   localparam int          B_OWNER         = 13;
   localparam int          B_IND_LO        = 14;
   localparam int          B_TEST_LO       = 16;
   localparam int          B_WAKE_CONN     = 20;
   localparam int          B_WAKE_DISC     = 21;
   localparam int          B_WAKE_OC       = 22;
   localparam int          B_ROUTE_FLAG    = 0;
   // reset values, test code limit and idle read data
   localparam logic        RST_OWNER       = 1'b1;
   localparam logic        RST_ROUTE_FLAG  = 1'b0;
   localparam logic [3:0]  TEST_NORMAL     = 4'h0;
   localparam logic [3:0]  TEST_MAX_LEGAL  = 4'h5;
   localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

   typedef struct packed {
      logic       connect;
      logic       overcurrent;
      logic [1:0] line_state;
   } hsp_pin_in_t;

   typedef struct packed {
      logic       owner_companion;
      logic       power;
      logic       enabled;
      logic       suspend;
      logic       force_resume;
      logic [3:0] test_mode;
      logic [2:0] wake_enable;
   } hsp_port_out_t;

   typedef struct packed {
      logic [2:0] wake;
      logic [3:0] test;
      logic       owner;
      logic       power;
      logic       suspend;
      logic       force_resume;
      logic       en_chg;
      logic       enabled;
      logic       conn_chg;
      logic       oc_chg;
   } hsp_port_reg_t;
endpackage

// File: core/hsp_port_bank.sv
// port routing flag and per-port status/control registers of the root hub
// assumes port pins are asynchronous and hc_reset_i is a same-clock pulse
//
// What this block does
// R1: flag zero routes ports to companion controllers
// R2: flag one routes ports to this controller
// R3: software sets flag after all other setup
// R4: port register at 50h plus four per port
// R5: port registers cleared only by power-up, controller reset
// R6: after reset ports disconnected and disabled
// R7: port state writes ignored until power set
// R8: software waits 20 ms for stable power
// R9: three wake enables default zero, gate wake events
// R10: test control zero normal, 1-5 modes, rest reserved
// R11: flag change reassigns every port owner immediately
`timescale 1ns/1ps
module hsp_port_bank (
   // clock and resets
   input  wire logic                                        clk_sys_i,
   input  wire logic                                        rstn_i,
   input  wire logic                                        hc_reset_i,
   // register port
   input  wire logic                                        reg_wr_i,
   input  wire logic                                        reg_rd_i,
   input  wire logic [7:0]                                  reg_addr_i,
   input  wire logic [31:0]                                 reg_wdata_i,
   output logic      [31:0]                                 reg_rdata_o,
   output logic                                             reg_rvalid_o,
   // root port pins
   input  wire hsp_pkg::hsp_pin_in_t  [hsp_pkg::NUM_PORTS-1:0] pin_i,
   output hsp_pkg::hsp_port_out_t     [hsp_pkg::NUM_PORTS-1:0] port_o,
   output logic                       [hsp_pkg::NUM_PORTS-1:0] wake_event_o
);
   import hsp_pkg::*;

   hsp_pin_in_t   [NUM_PORTS-1:0] pin_s1_q, pin_s2_q, pin_prev_q;
   hsp_port_reg_t [NUM_PORTS-1:0] prt_q, prt_d;
   hsp_port_out_t [NUM_PORTS-1:0] out_q, out_d;
   logic          [NUM_PORTS-1:0] wake_q, wake_d;
   logic                          flag_q, flag_d;
   logic          [31:0]          rdata_q, rdata_d;
   logic                          rvalid_q, rvalid_d;

   // two-flop synchronisers; stage one feeds stage two only
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_s1_q   <= pin_i;
         pin_s2_q   <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   function automatic logic [31:0] port_word(input hsp_port_reg_t r, input hsp_pin_in_t p);
      logic [31:0] w;
      w                               = READ_ZERO;
      w[B_CONN_STAT]                  = p.connect;
      w[B_CONN_CHG]                   = r.conn_chg;
      w[B_PORT_EN]                    = r.enabled;
      w[B_EN_CHG]                     = r.en_chg;
      w[B_OC_ACT]                     = p.overcurrent;
      w[B_OC_CHG]                     = r.oc_chg;
      w[B_FORCE_RES]                  = r.force_resume;
      w[B_SUSPEND]                    = r.suspend;
      w[B_LINE_LO +: 2]               = p.line_state;
      w[B_POWER]                      = r.power;
      w[B_OWNER]                      = r.owner;
      w[B_TEST_LO +: 4]               = r.test;
      w[B_WAKE_CONN]                  = r.wake[0];
      w[B_WAKE_DISC]                  = r.wake[1];
      w[B_WAKE_OC]                    = r.wake[2];
      return w;
   endfunction

   always_comb begin
      logic       hit;
      logic       conn_rise;
      logic       conn_fall;
      logic       oc_rise;
      logic       en_drop;
      logic [3:0] tst;
      hit       = 1'b0;
      conn_rise = 1'b0;
      conn_fall = 1'b0;
      oc_rise   = 1'b0;
      en_drop   = 1'b0;
      tst       = TEST_NORMAL;
      prt_d     = prt_q;
      flag_d    = flag_q;
      rdata_d   = READ_ZERO;
      rvalid_d  = reg_rd_i;
      wake_d    = '0;

      if (reg_wr_i && reg_addr_i == OFS_ROUTING)
         flag_d = reg_wdata_i[B_ROUTE_FLAG];
      if (reg_rd_i && reg_addr_i == OFS_ROUTING)
         rdata_d[B_ROUTE_FLAG] = flag_q;

      for (int i = 0; i < NUM_PORTS; i++) begin
         hit = reg_addr_i == OFS_PORT_SC + 8'(4 * i); // R4
         if (reg_rd_i && hit)
            rdata_d = port_word(prt_q[i], pin_s2_q[i]);
         conn_rise = pin_s2_q[i].connect && !pin_prev_q[i].connect;
         conn_fall = !pin_s2_q[i].connect && pin_prev_q[i].connect;
         oc_rise   = pin_s2_q[i].overcurrent != pin_prev_q[i].overcurrent;

         if (reg_wr_i && hit) begin
            prt_d[i].power = reg_wdata_i[B_POWER];
            prt_d[i].owner = reg_wdata_i[B_OWNER];
            prt_d[i].wake  = {reg_wdata_i[B_WAKE_OC], reg_wdata_i[B_WAKE_DISC],
                              reg_wdata_i[B_WAKE_CONN]}; // R9
            // unpowered port keeps its state; only power, owner and the wake enables move
            if (prt_q[i].power) begin // R7
               prt_d[i].suspend      = reg_wdata_i[B_SUSPEND];
               prt_d[i].force_resume = reg_wdata_i[B_FORCE_RES];
               // software may only disable; no logic in this block ever sets enable
               if (!reg_wdata_i[B_PORT_EN])
                  prt_d[i].enabled = 1'b0;
               if (reg_wdata_i[B_CONN_CHG])
                  prt_d[i].conn_chg = 1'b0;
               if (reg_wdata_i[B_EN_CHG])
                  prt_d[i].en_chg = 1'b0;
               if (reg_wdata_i[B_OC_CHG])
                  prt_d[i].oc_chg = 1'b0;
               tst = reg_wdata_i[B_TEST_LO +: 4];
               // reserved codes are dropped, previous mode kept
               if (tst <= TEST_MAX_LEGAL) // R10
                  prt_d[i].test = tst;
            end
         end

         // hardware events set after the clear so the set wins
         en_drop = prt_q[i].enabled && (conn_fall || pin_s2_q[i].overcurrent);
         if (conn_rise || conn_fall)
            prt_d[i].conn_chg = 1'b1;
         if (oc_rise)
            prt_d[i].oc_chg = 1'b1;
         if (en_drop) begin
            prt_d[i].enabled = 1'b0;
            prt_d[i].en_chg  = 1'b1;
         end
         wake_d[i] = prt_q[i].suspend && ((prt_q[i].wake[0] && conn_rise) ||
                     (prt_q[i].wake[1] && conn_fall) ||
                     (prt_q[i].wake[2] && oc_rise && pin_s2_q[i].overcurrent)); // R9

         // flag edge reroutes all ports at once
         if (flag_d != flag_q) // R11
            prt_d[i].owner = !flag_d; // R1 R2
      end

      if (hc_reset_i) begin // R5
         flag_d = RST_ROUTE_FLAG;
         for (int i = 0; i < NUM_PORTS; i++) begin
            prt_d[i]       = '0; // R6
            prt_d[i].owner = RST_OWNER;
         end
      end

      for (int i = 0; i < NUM_PORTS; i++) begin
         out_d[i].owner_companion = prt_d[i].owner;
         out_d[i].power           = prt_d[i].power;
         out_d[i].enabled         = prt_d[i].enabled;
         out_d[i].suspend         = prt_d[i].suspend;
         out_d[i].force_resume    = prt_d[i].force_resume;
         out_d[i].test_mode       = prt_d[i].test;
         out_d[i].wake_enable     = prt_d[i].wake;
      end
   end

   // only power-up reset is asynchronous; controller reset arrives synchronously through prt_d
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin // R5
         for (int i = 0; i < NUM_PORTS; i++) begin
            prt_q[i]                 <= '0; // R6
            prt_q[i].owner           <= RST_OWNER;
            out_q[i]                 <= '0;
            out_q[i].owner_companion <= RST_OWNER;
         end
         flag_q   <= RST_ROUTE_FLAG;
         wake_q   <= '0;
         rdata_q  <= READ_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         prt_q    <= prt_d;
         out_q    <= out_d;
         flag_q   <= flag_d;
         wake_q   <= wake_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata_o  = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign port_o       = out_q;
   assign wake_event_o = wake_q;
endmodule // hsp_port_bank

// File: verif/hsp_port_bank_assertions.sv
// checker for the port routing and status bank, port 0 watched in detail
// assumes it is bound to hsp_port_bank and sees only its ports
`timescale 1ns/1ps
module hsp_port_bank_assertions import hsp_pkg::*; (
   // clock and resets
   input wire logic                          clk_sys_i,
   input wire logic                          rstn_i,
   input wire logic                          hc_reset_i,
   // register port
   input wire logic                          reg_wr_i,
   input wire logic                          reg_rd_i,
   input wire logic [7:0]                    reg_addr_i,
   input wire logic [31:0]                   reg_wdata_i,
   input wire logic [31:0]                   reg_rdata_o,
   input wire logic                          reg_rvalid_o,
   // root ports
   input wire hsp_pin_in_t   [NUM_PORTS-1:0] pin_i,
   input wire hsp_port_out_t [NUM_PORTS-1:0] port_o,
   input wire logic          [NUM_PORTS-1:0] wake_event_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   logic           flag_d, flag_q, wrf, wr0;
   logic     [3:0] own;
   // a write in the controller reset cycle is lost
   assign wrf = reg_wr_i && !hc_reset_i && reg_addr_i == OFS_ROUTING;
   assign wr0 = reg_wr_i && !hc_reset_i && reg_addr_i == OFS_PORT_SC;
   always_comb begin
      flag_d = flag_q;
      if (hc_reset_i) flag_d = RST_ROUTE_FLAG;
      else if (wrf) flag_d = reg_wdata_i[B_ROUTE_FLAG];
      for (int i = 0; i < NUM_PORTS; i++) own[i] = port_o[i].owner_companion;
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) flag_q <= RST_ROUTE_FLAG;
      else flag_q <= flag_d;
   end
   sequence s_flag_flip;
      wrf && reg_wdata_i[B_ROUTE_FLAG] != flag_q;
   endsequence
   chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
   chk_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray rvalid");
   chk_rdata_idle: assert property (!reg_rvalid_o |-> reg_rdata_o == READ_ZERO)
      else $error("rdata not zero when idle");
   chk_flag_owner: assert property (s_flag_flip |=> own == {4{!$past(reg_wdata_i[0])}})
      else $error("owners not rerouted");
   chk_hc_restore: assert property (hc_reset_i |=> own == 4'hF && !port_o[0].power
      && !port_o[0].enabled && port_o[0].test_mode == TEST_NORMAL) else $error("bad hc reset");
   chk_power_gate: assert property (wr0 && !port_o[0].power |=>
      $stable(port_o[0].test_mode) && $stable(port_o[0].suspend)) else $error("unpowered write");
   chk_test_reserved: assert property (wr0 && reg_wdata_i[B_TEST_LO+:4] > TEST_MAX_LEGAL
      |=> $stable(port_o[0].test_mode)) else $error("reserved test code taken");
   chk_enable_write: assert property (wr0 && !port_o[0].enabled |=> !port_o[0].enabled)
      else $error("software enabled a port");
   chk_wake_cause: assert property (wake_event_o[0] |-> $past(port_o[0].suspend)
      && $past(port_o[0].wake_enable) != 3'h0) else $error("wake without enable");
endmodule // hsp_port_bank_assertions

// File: verif/hsp_pin_model.sv
// model of the devices attached to the root ports
// assumes the bench commands connect and overcurrent levels
`timescale 1ns/1ps
module hsp_pin_model import hsp_pkg::*; (
   // commands
   input  wire logic  [NUM_PORTS-1:0] conn_i,
   input  wire logic  [NUM_PORTS-1:0] oc_i,
   // port pins
   output hsp_pin_in_t [NUM_PORTS-1:0] pin_o
);
   // empty port pulled to se0 by the host pull-downs
   always_comb begin
      for (int i = 0; i < NUM_PORTS; i++) begin
         pin_o[i].connect     = conn_i[i];
         pin_o[i].overcurrent = oc_i[i];
         pin_o[i].line_state  = conn_i[i] ? 2'b01 : 2'b00;
      end
   end
endmodule // hsp_pin_model

// File: verif/testbench.sv
// self-checking bench for the port routing and status bank
// assumes the pin model stands in for attached devices
`timescale 1ns/1ps
module testbench;
   import hsp_pkg::*;
   logic                          clk_sys_i = 1'b0, rstn_i = 1'b0, hc = 1'b0;
   logic                          wr = 1'b0, rd = 1'b0, rvalid;
   logic          [7:0]           addr = 8'h00;
   logic          [31:0]          wdata = 32'h0, rdata;
   logic          [NUM_PORTS-1:0] conn = '0, oc = '0, own;
   hsp_pin_in_t   [NUM_PORTS-1:0] pins;
   hsp_port_out_t [NUM_PORTS-1:0] ports;
   int                            n_mismatch = 0, checks = 0;
   logic          [NUM_PORTS-1:0] wake;
   // settle wait scaled down; the full 20 ms would dwarf the whole run
   localparam int                 PWR_SETTLE = 20;
   initial forever #25 clk_sys_i = ~clk_sys_i;
   always_comb for (int i = 0; i < NUM_PORTS; i++) own[i] = ports[i].owner_companion;
   hsp_pin_model i_hsp_pin_model (.conn_i(conn), .oc_i(oc), .pin_o(pins));
   hsp_port_bank i_hsp_port_bank (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hc_reset_i(hc),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .pin_i(pins), .port_o(ports),
      .wake_event_o(wake));
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrt(logic [7:0] a, logic [31:0] d);
      @(negedge clk_sys_i);
      wr = 1'b1; addr = a; wdata = d;
      @(negedge clk_sys_i);
      wr = 1'b0;
   endtask
   task automatic rdc(logic [7:0] a, logic [31:0] exp);
      int n;
      @(negedge clk_sys_i);
      rd = 1'b1; addr = a;
      @(negedge clk_sys_i);
      rd = 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (rvalid !== 1'b1) begin
         n_mismatch++;
         test_done();
      end else
         cmp("rdata", rdata, exp);
   endtask
   // wake pulses last one cycle, so every falling edge is looked at
   task automatic cnt_wake(int p, int exp);
      int seen;
      seen = 0;
      repeat (8) begin
         @(negedge clk_sys_i);
         if (wake[p] === 1'b1)
            seen++;
      end
      cmp("wake pulses", 32'(seen), 32'(exp));
   endtask
   initial begin
      repeat (5) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      for (int p = 0; p < NUM_PORTS; p++) rdc(OFS_PORT_SC + 8'(4*p), 32'h2000);
      rdc(OFS_ROUTING, 32'h0);
      rdc(8'h60, 32'h0);
      cmp("owner", 32'(own), 32'hF);
      $display("test reset done");
      wrt(OFS_PORT_SC, 32'h0001_2084);
      rdc(OFS_PORT_SC, 32'h2000);
      wrt(OFS_PORT_SC, 32'h3000);
      repeat (PWR_SETTLE) @(negedge clk_sys_i);
      // codes above five keep the last legal one
      for (int t = 0; t < 16; t++) begin
         wrt(OFS_PORT_SC, 32'h3000 | (32'(t) << 16));
         cmp("test", 32'(ports[0].test_mode), (t > 5) ? 32'h5 : 32'(t));
      end
      wrt(OFS_PORT_SC, 32'h0070_3004);
      rdc(OFS_PORT_SC, 32'h0070_3000);
      cmp("wake", 32'(ports[0].wake_enable), 32'h7);
      $display("test port state done");
      wrt(8'h54, 32'h3000);
      conn[1] = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      rdc(8'h54, 32'h3403);
      wrt(8'h54, 32'h3002);
      rdc(8'h54, 32'h3401);
      conn[1] = 1'b0;
      $display("test connect done");
      wrt(8'h58, 32'h3000);
      repeat (PWR_SETTLE) @(negedge clk_sys_i);
      wrt(8'h58, 32'h0050_3080);
      conn[2] = 1'b1;
      cnt_wake(2, 1);
      rdc(8'h58, 32'h0050_3483);
      oc[2] = 1'b1;
      cnt_wake(2, 1);
      rdc(8'h58, 32'h0050_34B3);
      wrt(8'h58, 32'h0050_30A2);
      rdc(8'h58, 32'h0050_3491);
      // disconnect wake left off, and a falling overcurrent is no wake
      conn[2] = 1'b0;
      oc[2] = 1'b0;
      cnt_wake(2, 0);
      $display("test wake done");
      wrt(OFS_ROUTING, 32'h1);
      cmp("owner", 32'(own), 32'h0);
      rdc(OFS_ROUTING, 32'h1);
      rdc(OFS_PORT_SC, 32'h0070_1000);
      wrt(OFS_ROUTING, 32'h0);
      cmp("owner", 32'(own), 32'hF);
      $display("test routing done");
      @(negedge clk_sys_i);
      hc = 1'b1;
      @(negedge clk_sys_i);
      hc = 1'b0;
      rdc(OFS_PORT_SC, 32'h2000);
      rdc(8'h54, 32'h2000);
      rdc(8'h58, 32'h2000);
      $display("test controller reset done");
      test_done();
   end
endmodule // testbench
bind hsp_port_bank hsp_port_bank_assertions i_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
   .hc_reset_i(hc_reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .pin_i(pin_i), .port_o(port_o), .wake_event_o(wake_event_o));
